// [stp_map.svh]
// Purpose: Constants for the stepper driver serial control port
// Assumes: sys_clk at 250 MHz
// Notes:   Field positions are within the 12-bit setting word
`ifndef STP_MAP_SVH
`define STP_MAP_SVH

`define STP_WORD_BITS    12
`define STP_A_MD_BIT     11
`define STP_A_MAG_HI     10
`define STP_A_MAG_LO     7
`define STP_A_PH_BIT     6
`define STP_B_MD_BIT     5
`define STP_B_MAG_HI     4
`define STP_B_MAG_LO     1
`define STP_B_PH_BIT     0
`define STP_RESET_WORD   12'h000
`define STP_CLK_MHZ      250
`define STP_TPD_US       3
`define STP_TPD_CYC      (`STP_TPD_US * `STP_CLK_MHZ)
`define STP_OSC_DIV      10000

`endif

// [stp_pkg.sv]
// Purpose: Types for the stepper driver serial control port
// Assumes: Included map header for constants
// Notes:   Types only
package stp_pkg;
    typedef enum logic [1:0] {
        STP_CH_IDLE,
        STP_CH_ON,
        STP_CH_OFF
    } stp_chop_e;
endpackage

// [stp_coil.sv]
// Purpose: Per-coil chopper for one full bridge
// Assumes: Sense comparator already synchronised
// Notes:   Phase restart on polarity change
`timescale 1ns/1ps
`include "stp_map.svh"

module stp_coil
    import stp_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    // Controls
    input  wire logic       enable,
    input  wire logic       period_start,
    input  wire logic       restart,
    input  wire logic       polarity,
    input  wire logic [3:0] magnitude,
    input  wire logic       sense_over,
    // Gate outputs
    output logic            high_gate,
    output logic            low_gate
);
    typedef struct packed {
        stp_chop_e st;
        logic      hg;
        logic      lg;
    } stp_coil_s;

    stp_coil_s s;
    stp_coil_s next_s;

    // Chopper sequence
    always_comb begin
        next_s = s;
        case (s.st)
            STP_CH_IDLE: begin
                if (period_start || restart) begin
                    next_s.st = sense_over ? STP_CH_OFF : STP_CH_ON;
                end
            end
            STP_CH_ON: begin
                if (sense_over) begin
                    next_s.st = STP_CH_OFF;
                end
            end
            STP_CH_OFF: begin
                if (period_start) begin
                    next_s.st = sense_over ? STP_CH_OFF : STP_CH_ON;
                end
            end
            default: next_s.st = STP_CH_IDLE;
        endcase
        if (restart) begin
            next_s.st = sense_over ? STP_CH_OFF : STP_CH_ON;
        end
        if (!enable || magnitude == 4'h0) begin
            next_s.st = STP_CH_IDLE;
        end
        next_s.hg = (next_s.st == STP_CH_ON) && polarity;
        next_s.lg = (next_s.st == STP_CH_ON) && !polarity;
    end

    // State register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s <= '{STP_CH_IDLE, 1'b0, 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign high_gate = s.hg;
    assign low_gate  = s.lg;

    // --------------------------------------------------
    // Checks
    // --------------------------------------------------
    property p_zero_off;
        @(posedge sys_clk) disable iff (!nrst)
        (magnitude == 4'h0) |=> !(s.hg || s.lg);
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("gate on with zero magnitude");

    property p_skip_over;
        @(posedge sys_clk) disable iff (!nrst)
        (period_start && sense_over) |=> (s.st != STP_CH_ON);
    endproperty
    a_skip_over: assert property (p_skip_over) else $error("bridge on while sense over");

    property p_restart;
        @(posedge sys_clk) disable iff (!nrst)
        (restart && enable && magnitude != 4'h0 && !sense_over) |=> (s.st == STP_CH_ON);
    endproperty
    a_restart: assert property (p_restart) else $error("chopper not restarted");

    c_on: cover property (@(posedge sys_clk) disable iff (!nrst) s.st == STP_CH_ON);
endmodule

// [stp_top.sv]
// Purpose: Serial control port and chopper of a dual full-bridge stepper driver
// Assumes: Serial pins asynchronous to sys_clk; sampled through two flops
// Notes:   Serial clock well below sys_clk/4
`timescale 1ns/1ps
`include "stp_map.svh"

// Operation
// - Serial port is a shift register; chainable or individually selected.
// - Frames under twelve bits are rejected; settings stay unchanged.
// - Serial output floats while disabled or deselected.
// - New polarity reaches gates within oscillator period plus microseconds.
// - Polarity change restarts that coil's chopper only.
// - Bridge stays off for the period if sense already exceeded.
// - Zero magnitude switches the coil fully off.
module stp_top
    import stp_pkg::*;
#(
    parameter int OSC_DIV = `STP_OSC_DIV
)
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic nrst,
    // Serial pins
    input  wire logic spi_sck,
    input  wire logic spi_cs_n,
    input  wire logic spi_sdi,
    output logic      spi_sdo,
    output logic      spi_sdo_oe_n,
    // Driver control
    input  wire logic driver_disable_in,
    input  wire logic coil_a_sense_input,
    input  wire logic coil_b_sense_input,
    // Settings shown
    output logic      coil_a_polarity,
    output logic      coil_b_polarity,
    output logic      coil_a_mixed_decay,
    output logic      coil_b_mixed_decay,
    // Gate outputs
    output logic      coil_a_high_gate,
    output logic      coil_a_low_gate,
    output logic      coil_b_high_gate,
    output logic      coil_b_low_gate
);
    // Elaboration check: the oscillator needs room for two ticks per period
    if (OSC_DIV < 4) begin : g_bad_div
        $error("OSC_DIV too small");
    end

    // ----------------------------------------------
    // State
    // ----------------------------------------------
    typedef struct packed {
        logic [1:0]  sck_s;
        logic [1:0]  cs_s;
        logic [1:0]  sdi_s;
        logic [1:0]  dis_s;
        logic [1:0]  sa_s;
        logic [1:0]  sb_s;
        logic        sck_d;
        logic        cs_d;
        logic [11:0] shreg;
        logic [4:0]  cnt;
        logic [11:0] word;
        logic        sdo;
        logic        oe_n;
        logic [31:0] osc;
        logic        tick_a;
        logic        tick_b;
        logic        rst_a;
        logic        rst_b;
    } stp_top_s;

    stp_top_s s;
    stp_top_s next_s;
    logic     sck_rise;
    logic     sck_fall;
    logic     cs_rise;

    // Edges from synchronised copies only
    assign sck_rise = s.sck_s[1] && !s.sck_d;
    assign sck_fall = !s.sck_s[1] && s.sck_d;
    assign cs_rise  = s.cs_s[1] && !s.cs_d;

    // Next state
    always_comb begin
        next_s        = s;
        next_s.sck_s  = {s.sck_s[0], spi_sck};
        next_s.cs_s   = {s.cs_s[0], spi_cs_n};
        next_s.sdi_s  = {s.sdi_s[0], spi_sdi};
        next_s.dis_s  = {s.dis_s[0], driver_disable_in};
        next_s.sa_s   = {s.sa_s[0], coil_a_sense_input};
        next_s.sb_s   = {s.sb_s[0], coil_b_sense_input};
        next_s.sck_d  = s.sck_s[1];
        next_s.cs_d   = s.cs_s[1];
        next_s.rst_a  = 1'b0;
        next_s.rst_b  = 1'b0;
        next_s.tick_a = 1'b0;
        next_s.tick_b = 1'b0;
        if (!s.cs_s[1] && sck_rise) begin
            next_s.shreg = {s.shreg[10:0], s.sdi_s[1]};
            if (s.cnt != 5'h1F) begin
                next_s.cnt = s.cnt + 5'h01;
            end
        end
        // Shifted-out bit for the next device in the chain
        if (!s.cs_s[1] && sck_fall) begin
            next_s.sdo = s.shreg[11];
        end
        if (s.cs_s[1]) begin
            next_s.cnt = 5'h00;
        end
        // latch on select rising; short frame dropped; last twelve kept
        if (cs_rise && s.cnt >= 5'(`STP_WORD_BITS) && !s.dis_s[1]) begin
            next_s.word  = s.shreg;
            next_s.rst_a = s.shreg[`STP_A_PH_BIT] != s.word[`STP_A_PH_BIT];
            next_s.rst_b = s.shreg[`STP_B_PH_BIT] != s.word[`STP_B_PH_BIT];
        end
        next_s.oe_n = s.dis_s[1] || s.cs_s[1];
        // Chopper oscillator; coils chopped half a period apart
        if (s.osc >= 32'(OSC_DIV - 1)) begin
            next_s.osc    = 32'h0000_0000;
            next_s.tick_a = 1'b1;
        end else begin
            next_s.osc = s.osc + 32'h0000_0001;
        end
        next_s.tick_b = (s.osc == 32'(OSC_DIV / 2));
    end

    // State register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
            s.cs_s  <= 2'h3;
            s.cs_d  <= 1'b1;
            s.oe_n  <= 1'b1;
            s.word  <= `STP_RESET_WORD;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------
    // Coil choppers
    // ----------------------------------------------
    // polarity applied right after latch
    stp_coil u_coil_a (
        .sys_clk      (sys_clk),
        .nrst         (nrst),
        .enable       (!s.dis_s[1]),
        .period_start (s.tick_a),
        .restart      (s.rst_a),
        .polarity     (s.word[`STP_A_PH_BIT]),
        .magnitude    (s.word[`STP_A_MAG_HI:`STP_A_MAG_LO]),
        .sense_over   (s.sa_s[1]),
        .high_gate    (coil_a_high_gate),
        .low_gate     (coil_a_low_gate)
    );
    stp_coil u_coil_b (
        .sys_clk      (sys_clk),
        .nrst         (nrst),
        .enable       (!s.dis_s[1]),
        .period_start (s.tick_b),
        .restart      (s.rst_b),
        .polarity     (s.word[`STP_B_PH_BIT]),
        .magnitude    (s.word[`STP_B_MAG_HI:`STP_B_MAG_LO]),
        .sense_over   (s.sb_s[1]),
        .high_gate    (coil_b_high_gate),
        .low_gate     (coil_b_low_gate)
    );

    // Outputs from flops
    assign spi_sdo            = s.sdo;
    assign spi_sdo_oe_n       = s.oe_n;
    assign coil_a_polarity    = s.word[`STP_A_PH_BIT];
    assign coil_b_polarity    = s.word[`STP_B_PH_BIT];
    assign coil_a_mixed_decay = s.word[`STP_A_MD_BIT];
    assign coil_b_mixed_decay = s.word[`STP_B_MD_BIT];

    // ----------------------------------------------
    // Checks
    // ----------------------------------------------
    property p_short_drop;
        @(posedge sys_clk) disable iff (!nrst)
        (cs_rise && s.cnt < 5'(`STP_WORD_BITS)) |=> $stable(s.word);
    endproperty
    a_short_drop: assert property (p_short_drop) else $error("short frame changed settings");

    property p_latch;
        @(posedge sys_clk) disable iff (!nrst)
        (cs_rise && s.cnt >= 5'(`STP_WORD_BITS) && !s.dis_s[1]) |=> (s.word == $past(s.shreg));
    endproperty
    a_latch: assert property (p_latch) else $error("word not latched");

    property p_float;
        @(posedge sys_clk) disable iff (!nrst)
        ($past(spi_cs_n, 3) || $past(driver_disable_in, 3)) |-> spi_sdo_oe_n;
    endproperty
    a_float: assert property (p_float) else $error("sdo driven when idle");

    property p_restart_a;
        @(posedge sys_clk) disable iff (!nrst)
        $changed(s.word[`STP_A_PH_BIT]) |-> s.rst_a && !s.rst_b || $changed(s.word[`STP_B_PH_BIT]);
    endproperty
    a_restart_a: assert property (p_restart_a) else $error("restart missing");

    property p_pol_fast;
        @(posedge sys_clk) disable iff (!nrst)
        (s.rst_a && !s.dis_s[1] && s.word[10:7] != 4'h0 && !s.sa_s[1])
            |-> ##[1:2] (coil_a_high_gate == s.word[`STP_A_PH_BIT]);
    endproperty
    a_pol_fast: assert property (p_pol_fast) else $error("polarity slow");

    c_frame: cover property (@(posedge sys_clk) disable iff (!nrst) cs_rise && s.cnt == 5'h10);
    c_short: cover property (@(posedge sys_clk) disable iff (!nrst) cs_rise && s.cnt == 5'h0B);
    c_flip: cover property (@(posedge sys_clk) disable iff (!nrst) s.rst_b);
endmodule

// [stp_host.sv]
// Purpose: Host serial master model for the control port
// Assumes: Moves its pins at sys_clk falling edge
// Notes:   Clock idles low; released data line inverts
`timescale 1ns/1ps

module stp_host (
    // Clock
    input  wire logic sys_clk,
    // Serial pins
    output logic      spi_sck,
    output logic      spi_cs_n,
    output logic      spi_sdi,
    input  wire logic spi_sdo
);
    logic [23:0] captured;

    // Idle bus
    initial begin
        spi_sck  = 1'b0;
        spi_cs_n = 1'b1;
        spi_sdi  = 1'b0;
        captured = 24'h000000;
    end

    // Half serial period, well above three sys_clk
    task automatic half();
        repeat (8) @(negedge sys_clk);
    endtask

    task automatic send(input logic [23:0] word, input int nbits);
        spi_cs_n = 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            spi_sdi = word[i];
            half();
            spi_sck  = 1'b1;
            captured = {captured[22:0], spi_sdo};
            half();
            spi_sck = 1'b0;
        end
        half();
        spi_cs_n = 1'b1;
        // No stale level once released
        spi_sdi = ~spi_sdi;
        half();
    endtask
endmodule

// [stp_tb.sv]
// Purpose: Self-checking bench for the serial control port
// Assumes: Short chopper period of 20 cycles
// Notes:   Inputs move at sys_clk falling edge
`timescale 1ns/1ps
`include "stp_map.svh"

module tb;
    localparam int DIV = 20;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic dis = 1'b1;
    logic sns_a = 1'b0;
    logic sck, cs_n, sdi, sdo, oe_n, pa, pb, da, db, ha, la, hb, lb;
    int   mismatches = 0;
    int   checks_done = 0;

    always #2 sys_clk = ~sys_clk;

    stp_top #(.OSC_DIV(DIV)) i_stp_top (.sys_clk(sys_clk), .nrst(nrst), .spi_sck(sck), .spi_cs_n(cs_n),
        .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe_n(oe_n), .driver_disable_in(dis),
        .coil_a_sense_input(sns_a), .coil_b_sense_input(1'b0), .coil_a_polarity(pa), .coil_b_polarity(pb),
        .coil_a_mixed_decay(da), .coil_b_mixed_decay(db), .coil_a_high_gate(ha), .coil_a_low_gate(la),
        .coil_b_high_gate(hb), .coil_b_low_gate(lb));
    stp_host i_stp_host (.sys_clk(sys_clk), .spi_sck(sck), .spi_cs_n(cs_n), .spi_sdi(sdi), .spi_sdo(sdo));

    // Verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Compare seen against expected
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Expected visible settings of a word
    function automatic logic [11:0] vis(input logic [11:0] w);
        return {8'h00, w[11], w[6], w[5], w[0]};
    endfunction

    // Cycles over two periods with any coil A gate on
    task automatic count_a(output int n);
        n = 0;
        repeat (2 * DIV) begin
            @(negedge sys_clk);
            if (ha !== 1'b0 || la !== 1'b0) n++;
        end
    endtask

    task automatic t_latch();
        int n;
        fork
            i_stp_host.send(24'h000FC1, 12);
            begin
                repeat (20) @(negedge sys_clk);
                chk(12'(oe_n), 12'h000);
            end
        join
        chk({8'h00, da, pa, db, pb}, vis(12'hFC1));
        n = 0;
        while (ha !== 1'b1 && la !== 1'b1) begin
            @(negedge sys_clk);
            n++;
            if (n > 3000) begin
                mismatches++;
                results();
            end
        end
        chk(12'(n <= DIV + `STP_TPD_CYC), 12'h001);
        chk({10'h000, ha, la}, 12'h002);
        $display("test latch done");
    endtask

    task automatic t_pad_short();
        int n;
        i_stp_host.send({8'h00, 4'hF, 12'h021}, 16);
        chk({8'h00, da, pa, db, pb}, vis(12'h021));
        i_stp_host.send(24'h000FFF, 11);
        chk({8'h00, da, pa, db, pb}, vis(12'h021));
        count_a(n);
        chk(12'(n), 12'h000);
        $display("test pad and short done");
    endtask

    task automatic t_chain_sense();
        int n;
        i_stp_host.send({12'h843, 12'hFC1}, 24);
        chk({8'h00, da, pa, db, pb}, vis(12'hFC1));
        chk(i_stp_host.captured[11:0], 12'h843);
        chk({10'h000, ha, la}, 12'h002);
        sns_a = 1'b1;
        // Let the sense level pass the synchroniser first
        repeat (4) @(negedge sys_clk);
        count_a(n);
        chk(12'(n), 12'h000);
        sns_a = 1'b0;
        $display("test chain and sense done");
    endtask

    task automatic t_disable();
        int n;
        dis = 1'b1;
        repeat (6) @(negedge sys_clk);
        chk(12'(oe_n), 12'h001);
        count_a(n);
        chk(12'(n), 12'h000);
        fork
            i_stp_host.send(24'h000000, 12);
            begin
                repeat (20) @(negedge sys_clk);
                chk(12'(oe_n), 12'h001);
            end
        join
        chk({8'h00, da, pa, db, pb}, vis(12'hFC1));
        dis = 1'b0;
        repeat (7500) @(negedge sys_clk);
        i_stp_host.send(24'h000022, 12);
        chk({8'h00, da, pa, db, pb}, vis(12'h022));
        chk({10'h000, hb, lb}, 12'h001);
        $display("test disable done");
    endtask

    // Main sequence
    initial begin
        repeat (6) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk({8'h00, da, pa, db, pb}, 12'h000);
        chk(12'(oe_n), 12'h001);
        dis = 1'b0;
        // Host waits 30 us after enabling
        repeat (7500) @(negedge sys_clk);
        t_latch();
        t_pad_short();
        t_chain_sense();
        t_disable();
        results();
    end
endmodule
